/* core/tasc_regs.svh */
// Register offsets, field positions, reset values and timing counts
// of the touch ADC sequence controller; included by its bare name.
`ifndef TASC_REGS_SVH
`define TASC_REGS_SVH

// ============================================================
// Serial word layout: 4-bit address then 12 data bits
`define TASC_WORD_BITS 16
`define TASC_ADDR_LSB 12

// ============================================================
// Register addresses
`define TASC_ADDR_MODE_CTRL 4'h1
`define TASC_ADDR_TIMING 4'h2
`define TASC_ADDR_SLAVE_MASK 4'h3
`define TASC_ADDR_MASTER_MASK 4'h4
`define TASC_ADDR_RESULT_BASE 4'h5
`define TASC_NUM_CHANNELS 11

// ============================================================
// Mode control fields
`define TASC_MODE_LSB 10
`define TASC_CHAN_LSB 6
`define TASC_RDSEL_LSB 0
`define TASC_MODE_IDLE 2'h0
`define TASC_MODE_SINGLE 2'h1
`define TASC_MODE_SLAVE 2'h2
`define TASC_MODE_MASTER 2'h3

// ============================================================
// Timing config fields
`define TASC_AVG_LSB 10
`define TASC_ACQ_LSB 8
`define TASC_PM_LSB 6
`define TASC_FCD_LSB 4
`define TASC_POL_BIT 3
`define TASC_TMR_LSB 0
`define TASC_PM_OFF 2'h0
`define TASC_PM_AUTO_ALL 2'h1
`define TASC_PM_FULL 2'h2
`define TASC_PM_AUTO_ADC 2'h3

// ============================================================
// Reset values
`define TASC_RST_MODE_CTRL 12'h000
`define TASC_RST_TIMING 12'h000
`define TASC_RST_MASK 12'h000

// ============================================================
// Timing, in conversion clocks unless named otherwise
`define TASC_REF_CLK_NS 50
`define TASC_CONV_CLK_NS 500
`define TASC_FCD_CLKS_0 16'h0001
`define TASC_FCD_CLKS_1 16'h0100
`define TASC_FCD_CLKS_2 16'h0800
`define TASC_FCD_CLKS_3 16'h4000
`define TASC_ACQ_CLKS_0 16'h0004
`define TASC_ACQ_CLKS_1 16'h0008
`define TASC_ACQ_CLKS_2 16'h0010
`define TASC_ACQ_CLKS_3 16'h0020
`define TASC_TMR_CLKS_1 16'h0400
`define TASC_TMR_CLKS_2 16'h0800
`define TASC_TMR_CLKS_3 16'h4000
`define TASC_AVG_SHIFT_0 3'h0
`define TASC_AVG_SHIFT_1 3'h2
`define TASC_AVG_SHIFT_2 3'h3
`define TASC_AVG_SHIFT_3 3'h4

`endif

/* core/tasc_pkg.sv */
// Types shared by the touch ADC sequence controller files.
// Assumes nothing of its surroundings.
package tasc_pkg;

  // ============================================================
  // Sequencer states
  typedef enum logic [2:0] {
    TASC_IDLE,
    TASC_WAIT_TOUCH,
    TASC_DELAY,
    TASC_ACQ,
    TASC_CONV,
    TASC_POST,
    TASC_REPEAT
  } tasc_state_t;

endpackage

/* core/tasc_avg.sv */
// Accumulator that averages 1, 4, 8 or 16 conversions of one channel.
// Assumes the caller clears it before each channel and adds one sample at a time.
`timescale 1ns/100ps
module tasc_avg #(
  parameter int DATA_W = 12
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic add_i,
  input wire logic [DATA_W-1:0] sample_i,
  input wire logic [2:0] shift_i,
  output logic [DATA_W-1:0] avg_o
);

  // ============================================================
  // Running sum; four guard bits hold sixteen full-scale samples
  logic [DATA_W+3:0] acc;
  wire [DATA_W+3:0] sum_with_new = acc + {4'h0, sample_i};
  wire [DATA_W+3:0] shifted = sum_with_new >> shift_i;

  // Elaboration check; a zero-width sample has nothing to average
  if (DATA_W < 1) $error("tasc_avg: DATA_W must be positive");

  // Sum kept until the next channel starts
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || clear_i) begin
      acc <= '0;
    end else if (add_i) begin
      acc <= sum_with_new;
    end
  end

  // Average includes the sample arriving now, so the last one is not lost
  assign avg_o = shifted[DATA_W-1:0];

endmodule // tasc_avg

/* core/tasc_top.sv */
// Conversion sequencer of a touch-screen ADC with its serial register port.
// Assumes an analog converter on the same clock (start, done, data) and
// asynchronous panel, inhibit and serial pins that are synchronised here.
//
// Summary of operation
// [R1] Inhibit input is active high when polarity bit is 1, else low; none sample.
// [R2] First-delay code selects 1, 256, 2048 or 16384 clocks before first conversion.
// [R3] First delay also precedes X/Y channels and follows the final conversion.
// [R4] Inhibit is ignored while the first delay is running.
// [R5] Power policy 00 keeps converter off and overrides any selected mode.
// [R6] Policy 01 powers converter and reference only while converting.
// [R7] Policy 10 keeps both powered; 11 powers only the converter down.
// [R8] Host uses master sequencing only with policy 01 or 11.
// [R9] Sample time code selects 4, 8, 16 or 32 clocks.
// [R10] Averaging code selects 1, 4, 8 or 16 conversions per channel.
// [R11] Only the final average reaches the result register.
// [R12] Mask bit 11 enables channel 0 down to bit 1 channel 10; bit 0 unused.
// [R13] Slave sequences use the slave mask, master sequences the master mask.
// [R14] Results-ready output is high while idle or converting, low after results.
// [R15] A host read of a result register returns results-ready high.
// [R16] Repeat timer expiry restarting a sequence returns results-ready high.
// [R17] Host reads results only while results-ready is low.
// [R18] With repeat on, host finishes reads before the timer expires.
// [R19] Touch interrupt idles high and goes low while the screen is touched.
// [R20] Touch detection works always except during a conversion.
// [R21] Touch end releases interrupt at once when idle, else when idle again.
// [R22] Modes 01/10 are host-started slave; mode 11 is touch-started master.
// [R23] Repeat code selects single run or repeats every 1024, 2048, 16384 clocks.
// [R24] Master repeat runs only while touched; release stops it, next touch starts.
// [R25] Active inhibit outside the first delay holds the sampling phase off.
`timescale 1ns/100ps
`include "tasc_regs.svh"
module tasc_top #(
  parameter int FCD_LONG_CLKS = `TASC_FCD_CLKS_3,
  parameter int TMR_LONG_CLKS = `TASC_TMR_CLKS_3,
  parameter int DATA_W = 12
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic touch_i,
  input wire logic acq_inhibit_in_i,
  input wire logic adc_done_i,
  input wire logic [DATA_W-1:0] adc_data_i,
  output logic sdo_o,
  output logic results_ready_n_o,
  output logic touch_irq_n_o,
  output logic adc_start_o,
  output logic [3:0] adc_chan_o,
  output logic sample_o,
  output logic adc_power_o,
  output logic ref_power_o
);

  localparam int CONV_DIV = `TASC_CONV_CLK_NS / `TASC_REF_CLK_NS;

  localparam logic [11:0] RST_MODE = `TASC_RST_MODE_CTRL;

  // Elaboration checks: step counter is 16 bits, registers 12 bits wide
  if (FCD_LONG_CLKS < 1 || FCD_LONG_CLKS > 65535) $error("tasc_top: FCD_LONG_CLKS out of range");
  if (TMR_LONG_CLKS < 1 || TMR_LONG_CLKS > 65535) $error("tasc_top: TMR_LONG_CLKS out of range");
  if (DATA_W != 12) $error("tasc_top: DATA_W must match the 12-bit register width");

  // ============================================================
  // Pin synchronisers; stage one is read only by stage two
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic [1:0] edge_hist;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_s1 <= 5'h02; // Idle levels: sclk low, select high
      pin_s2 <= 5'h02;
      edge_hist <= 2'h2; // No false sclk edge after reset
    end else begin
      pin_s1 <= {acq_inhibit_in_i, touch_i, sdi_i, cs_n_i, sclk_i};
      pin_s2 <= pin_s1;
      edge_hist <= pin_s2[1:0];
    end
  end
  wire sclk_s = pin_s2[0];
  wire cs_n_s = pin_s2[1];
  wire sdi_s = pin_s2[2];
  wire touch_s = pin_s2[3];
  wire inhibit_s = pin_s2[4];
  wire sclk_rise = sclk_s && !edge_hist[0];
  wire sclk_fall = !sclk_s && edge_hist[0];
  wire cs_fall = !cs_n_s && edge_hist[1];

  // ============================================================
  // Conversion clock enable, one pulse per 500 ns
  logic [3:0] div_cnt;
  wire conv_tick = (div_cnt == 4'(CONV_DIV - 1));
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || conv_tick) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // ============================================================
  // Register state
  logic [1:0] mode;
  logic [3:0] single_chan;
  logic [3:0] rd_sel;
  logic [11:0] timing_cfg;
  logic [11:0] slave_sequence_channel_mask;
  logic [11:0] master_sequence_channel_mask;
  logic [11:0] results [`TASC_NUM_CHANNELS];

  wire [1:0] avg_sel = timing_cfg[`TASC_AVG_LSB +: 2];
  wire [1:0] sample_time_sel = timing_cfg[`TASC_ACQ_LSB +: 2];
  wire [1:0] power_policy = timing_cfg[`TASC_PM_LSB +: 2];
  wire [1:0] first_conv_delay_sel = timing_cfg[`TASC_FCD_LSB +: 2];
  wire inhibit_polarity = timing_cfg[`TASC_POL_BIT];
  wire [1:0] repeat_timer_sel = timing_cfg[`TASC_TMR_LSB +: 2];

  // ============================================================
  // Serial port: mode 0, 16-bit words, sampled on the reference clock
  logic [4:0] bit_cnt;
  logic [14:0] in_sr;
  logic [15:0] out_sr;
  logic [3:0] out_sel;
  wire frame_done = sclk_rise && !cs_n_s && (bit_cnt == 5'd15);
  wire [15:0] rx_word = {in_sr, sdi_s};
  wire [3:0] wr_addr = rx_word[15:`TASC_ADDR_LSB];
  wire [11:0] wr_data = rx_word[11:0];
  wire [3:0] rd_idx = rd_sel - `TASC_ADDR_RESULT_BASE;
  wire rd_is_result = (rd_sel >= `TASC_ADDR_RESULT_BASE);
  wire out_is_result = (out_sel >= `TASC_ADDR_RESULT_BASE);
  wire host_result_read = frame_done && out_is_result; // R15

  // Read mux by address
  logic [11:0] rd_data;
  assign rd_data = (rd_sel == `TASC_ADDR_MODE_CTRL) ? {mode, single_chan, 2'h0, rd_sel} :
                   (rd_sel == `TASC_ADDR_TIMING) ? timing_cfg :
                   (rd_sel == `TASC_ADDR_SLAVE_MASK) ? slave_sequence_channel_mask :
                   (rd_sel == `TASC_ADDR_MASTER_MASK) ? master_sequence_channel_mask :
                   rd_is_result ? results[rd_idx] : 12'h000;

  // Shift in on rising, out on falling clock edges
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || cs_fall) begin
      bit_cnt <= 5'h00;
      in_sr <= 15'h0000;
      out_sr <= rst_i ? 16'h0000 : {rd_sel, rd_data};
      out_sel <= rst_i ? 4'h0 : rd_sel;
    end else if (!cs_n_s) begin
      if (sclk_rise) begin
        in_sr <= rx_word[14:0];
        bit_cnt <= frame_done ? 5'h00 : bit_cnt + 5'h01;
      end
      if (sclk_fall) begin
        out_sr <= {out_sr[14:0], 1'b0};
      end
    end
  end

  // ============================================================
  // Sequencer state and decoded timing
  tasc_pkg::tasc_state_t state;
  tasc_pkg::tasc_state_t next_state;
  logic [15:0] cnt;
  logic [3:0] chan;
  logic [4:0] avg_done_cnt;
  logic is_master;
  logic fsm_clear_mode;

  wire [15:0] fcd_clks = (first_conv_delay_sel == 2'h0) ? `TASC_FCD_CLKS_0 :
                         (first_conv_delay_sel == 2'h1) ? `TASC_FCD_CLKS_1 :
                         (first_conv_delay_sel == 2'h2) ? `TASC_FCD_CLKS_2 : 16'(FCD_LONG_CLKS); // R2
  wire [15:0] acq_clks = (sample_time_sel == 2'h0) ? `TASC_ACQ_CLKS_0 :
                         (sample_time_sel == 2'h1) ? `TASC_ACQ_CLKS_1 :
                         (sample_time_sel == 2'h2) ? `TASC_ACQ_CLKS_2 : `TASC_ACQ_CLKS_3; // R9
  wire [15:0] tmr_clks = (repeat_timer_sel == 2'h1) ? `TASC_TMR_CLKS_1 :
                         (repeat_timer_sel == 2'h2) ? `TASC_TMR_CLKS_2 : 16'(TMR_LONG_CLKS); // R23
  wire [2:0] avg_shift = (avg_sel == 2'h0) ? `TASC_AVG_SHIFT_0 :
                         (avg_sel == 2'h1) ? `TASC_AVG_SHIFT_1 :
                         (avg_sel == 2'h2) ? `TASC_AVG_SHIFT_2 : `TASC_AVG_SHIFT_3; // R10
  wire [4:0] avg_total = 5'h01 << avg_shift;
  wire inhibit_active = inhibit_polarity ? inhibit_s : !inhibit_s; // R1
  wire cnt_last = conv_tick && (cnt + 16'h0001 >= (state == tasc_pkg::TASC_ACQ ? acq_clks :
                  state == tasc_pkg::TASC_REPEAT ? tmr_clks : fcd_clks));
  wire busy = (state != tasc_pkg::TASC_IDLE) && (state != tasc_pkg::TASC_WAIT_TOUCH) &&
              (state != tasc_pkg::TASC_REPEAT); // R20
  wire [11:0] seq_mask = is_master ? master_sequence_channel_mask : slave_sequence_channel_mask; // R13

  // First enabled channel at or above a start index; bit 11 is channel 0
  function automatic logic [4:0] tasc_find(input logic [11:0] mask, input logic [4:0] from);
    logic [4:0] hit;
    hit = 5'h1f;
    for (int i = `TASC_NUM_CHANNELS - 1; i >= 0; i--) begin
      if (mask[11 - i] && 5'(i) >= from) hit = 5'(i); // R12
    end
    return hit;
  endfunction

  wire [4:0] first_hit = tasc_find(seq_mask, 5'h00);
  wire [4:0] next_hit = tasc_find(seq_mask, {1'b0, chan} + 5'h01);
  wire single_run = (mode == `TASC_MODE_SINGLE);
  wire [3:0] start_chan = single_run ? single_chan : first_hit[3:0];
  wire start_ok = single_run || (first_hit != 5'h1f);
  wire avg_last = (avg_done_cnt + 5'h01 == avg_total);
  wire chan_done = (state == tasc_pkg::TASC_CONV) && adc_done_i && avg_last;
  wire more_chans = !single_run && (next_hit != 5'h1f);
  wire seq_done = chan_done && !more_chans;
  wire timer_restart = (state == tasc_pkg::TASC_REPEAT) && cnt_last && (!is_master || touch_s);
  wire acq_done = (state == tasc_pkg::TASC_ACQ) && cnt_last && !inhibit_active;
  wire [DATA_W-1:0] avg_value;

  // ============================================================
  // Next-state logic
  always_comb begin
    next_state = state;
    fsm_clear_mode = 1'b0;
    case (state)
      tasc_pkg::TASC_IDLE: begin
        if (mode == `TASC_MODE_MASTER) begin
          next_state = tasc_pkg::TASC_WAIT_TOUCH; // R22
        end else if (mode != `TASC_MODE_IDLE) begin
          next_state = start_ok ? tasc_pkg::TASC_DELAY : tasc_pkg::TASC_IDLE;
          fsm_clear_mode = !start_ok;
        end
      end
      tasc_pkg::TASC_WAIT_TOUCH: begin
        if (mode != `TASC_MODE_MASTER) begin
          next_state = tasc_pkg::TASC_IDLE;
        end else if (touch_s && start_ok) begin
          next_state = tasc_pkg::TASC_DELAY; // R24
        end
      end
      tasc_pkg::TASC_DELAY: begin
        if (cnt_last) next_state = tasc_pkg::TASC_ACQ; // R4
      end
      tasc_pkg::TASC_ACQ: begin
        if (acq_done) next_state = tasc_pkg::TASC_CONV; // R25
      end
      tasc_pkg::TASC_CONV: begin
        if (seq_done) begin
          next_state = tasc_pkg::TASC_POST; // R3
        end else if (chan_done) begin
          next_state = (next_hit < 5'h02) ? tasc_pkg::TASC_DELAY : tasc_pkg::TASC_ACQ; // R3
        end else if (adc_done_i) begin
          next_state = tasc_pkg::TASC_ACQ; // R10
        end
      end
      tasc_pkg::TASC_POST: begin
        if (cnt_last) begin
          if (single_run || (!is_master && repeat_timer_sel == 2'h0)) begin
            next_state = tasc_pkg::TASC_IDLE;
            fsm_clear_mode = 1'b1;
          end else if (is_master && (repeat_timer_sel == 2'h0 || !touch_s)) begin
            next_state = tasc_pkg::TASC_WAIT_TOUCH;
          end else begin
            next_state = tasc_pkg::TASC_REPEAT; // R23
          end
        end
      end
      tasc_pkg::TASC_REPEAT: begin
        if (mode == `TASC_MODE_IDLE) begin
          next_state = tasc_pkg::TASC_IDLE;
        end else if (is_master && !touch_s) begin
          next_state = tasc_pkg::TASC_WAIT_TOUCH; // R24
        end else if (timer_restart) begin
          next_state = tasc_pkg::TASC_DELAY;
        end
      end
      default: next_state = tasc_pkg::TASC_IDLE;
    endcase
    if (power_policy == `TASC_PM_OFF) begin
      next_state = tasc_pkg::TASC_IDLE; // R5
    end
  end

  wire starting = (next_state == tasc_pkg::TASC_DELAY) &&
                  (state == tasc_pkg::TASC_IDLE || state == tasc_pkg::TASC_WAIT_TOUCH ||
                   state == tasc_pkg::TASC_REPEAT);

  // ============================================================
  // State, counter and channel registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= tasc_pkg::TASC_IDLE;
      cnt <= 16'h0000;
      chan <= 4'h0;
      avg_done_cnt <= 5'h00;
      is_master <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        cnt <= 16'h0000;
      end else if (conv_tick && !(state == tasc_pkg::TASC_ACQ && inhibit_active)) begin
        cnt <= cnt + 16'h0001; // R25
      end
      if (state == tasc_pkg::TASC_IDLE) begin
        is_master <= (mode == `TASC_MODE_MASTER);
      end
      if (starting) begin
        chan <= start_chan;
        avg_done_cnt <= 5'h00;
      end else if (chan_done) begin
        chan <= next_hit[3:0];
        avg_done_cnt <= 5'h00;
      end else if (state == tasc_pkg::TASC_CONV && adc_done_i) begin
        avg_done_cnt <= avg_done_cnt + 5'h01;
      end
    end
  end

  // ============================================================
  // Averaging unit; cleared at each channel so sums never mix
  tasc_avg #(
    .DATA_W(DATA_W)
  ) u_avg (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clear_i(starting || chan_done),
    .add_i(state == tasc_pkg::TASC_CONV && adc_done_i),
    .sample_i(adc_data_i),
    .shift_i(avg_shift),
    .avg_o(avg_value)
  );

  // Result store written only with the final average
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `TASC_NUM_CHANNELS; i++) results[i] <= 12'h000;
    end else if (chan_done) begin
      results[chan] <= avg_value; // R11
    end
  end

  // ============================================================
  // Host-written registers; a mode write wins over the sequencer's clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      {mode, single_chan, rd_sel} <= {RST_MODE[11:6], RST_MODE[3:0]};
      timing_cfg <= `TASC_RST_TIMING;
      slave_sequence_channel_mask <= `TASC_RST_MASK;
      master_sequence_channel_mask <= `TASC_RST_MASK;
    end else begin
      if (frame_done && wr_addr == `TASC_ADDR_MODE_CTRL) begin
        mode <= (power_policy == `TASC_PM_OFF) ? `TASC_MODE_IDLE : wr_data[`TASC_MODE_LSB +: 2]; // R5
        single_chan <= wr_data[`TASC_CHAN_LSB +: 4];
        rd_sel <= wr_data[`TASC_RDSEL_LSB +: 4];
      end else if (fsm_clear_mode || power_policy == `TASC_PM_OFF) begin
        mode <= `TASC_MODE_IDLE;
      end
      if (frame_done && wr_addr == `TASC_ADDR_TIMING) timing_cfg <= wr_data;
      if (frame_done && wr_addr == `TASC_ADDR_SLAVE_MASK) slave_sequence_channel_mask <= {wr_data[11:1], 1'b0};
      if (frame_done && wr_addr == `TASC_ADDR_MASTER_MASK) master_sequence_channel_mask <= {wr_data[11:1], 1'b0};
    end
  end

  // ============================================================
  // Output flops; results-ready set wins over a same-cycle clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      results_ready_n_o <= 1'b1;
      touch_irq_n_o <= 1'b1;
      adc_start_o <= 1'b0;
      adc_chan_o <= 4'h0;
      sample_o <= 1'b0;
      adc_power_o <= 1'b0;
      ref_power_o <= 1'b0;
      sdo_o <= 1'b0;
    end else begin
      if (seq_done) begin
        results_ready_n_o <= 1'b0; // R14
      end else if (host_result_read || timer_restart || starting) begin
        results_ready_n_o <= 1'b1; // R16
      end
      if (!busy) begin
        touch_irq_n_o <= !touch_s; // R19 R21
      end
      adc_start_o <= acq_done;
      adc_chan_o <= chan;
      sample_o <= (state == tasc_pkg::TASC_ACQ) && !inhibit_active; // R1
      adc_power_o <= (power_policy == `TASC_PM_FULL) || ((power_policy != `TASC_PM_OFF) && busy); // R6
      ref_power_o <= (power_policy == `TASC_PM_FULL) || (power_policy == `TASC_PM_AUTO_ADC) ||
                     ((power_policy == `TASC_PM_AUTO_ALL) && busy); // R7
      sdo_o <= !cs_n_s && out_sr[15];
    end
  end

endmodule // tasc_top

/* bench/tasc_host_model.sv */
// Host stand-in on the serial register port.
// Assumes a 400 ns serial clock and calls starting on the core clock.
`timescale 1ns/100ps
module tasc_host_model (
  input wire logic ref_clk_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o
);
  // ============================================================
  // Serial frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  // One 16-bit word, MSB first; sdo taken on each sclk rise
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(posedge ref_clk_i);
    #1 cs_n_o = 1'b0;
    #400;
    for (int i = 15; i >= 0; i--) begin
      sdi_o = w[i];
      #200 sclk_o = 1'b1;
      r[i] = sdo_i;
      #200 sclk_o = 1'b0;
    end
    #200 cs_n_o = 1'b1;
    sdi_o = ~sdi_o; // Released line must not keep the last bit
    #400;
  endtask
endmodule // tasc_host_model

/* bench/tasc_props.sv */
// Assertions on the sequencer's pins.
// Assumes it is bound into tasc_top and sees its ports only.
`timescale 1ns/100ps
module tasc_props (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic touch_i,
  input wire logic adc_done_i,
  input wire logic results_ready_n_o,
  input wire logic touch_irq_n_o,
  input wire logic adc_start_o,
  input wire logic [3:0] adc_chan_o,
  input wire logic sample_o,
  input wire logic adc_power_o
);
  // ============================================================
  // Properties
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // Reset state, and the converter handshake
  rst_val_a: assert property ($fell(rst_i) |-> results_ready_n_o && touch_irq_n_o && !adc_power_o)
    else $error("outputs wrong after reset");
  ready_hi_a: assert property (sample_o |-> results_ready_n_o)
    else $error("ready low while sampling");
  ready_fall_a: assert property ($fell(results_ready_n_o) |-> $past(adc_done_i))
    else $error("ready fell without a finished conversion");
  start_pulse_a: assert property (adc_start_o |=> !adc_start_o)
    else $error("start longer than one cycle");
  start_cause_a: assert property (adc_start_o |-> $past(sample_o) || $past(sample_o, 2))
    else $error("start without sampling phase");
  chan_range_a: assert property (adc_start_o |-> adc_chan_o <= 4'ha)
    else $error("start on a channel beyond 10");
  power_on_a: assert property (sample_o || adc_start_o |-> adc_power_o)
    else $error("converting while powered down");
  // Sync chain delays the pin by a few cycles
  irq_cause_a: assert property ($fell(touch_irq_n_o) |-> $past(touch_i) || $past(touch_i, 2) || $past(touch_i, 3))
    else $error("touch flag without touch");

  cov_done_c: cover property ($fell(results_ready_n_o));
  cov_touch_c: cover property ($fell(touch_irq_n_o));
  cov_conv_c: cover property (adc_start_o ##[1:20] adc_done_i);
endmodule // tasc_props

bind tasc_top tasc_props u_props (.ref_clk_i, .rst_i, .touch_i, .adc_done_i, .results_ready_n_o,
  .touch_irq_n_o, .adc_start_o, .adc_chan_o, .sample_o, .adc_power_o);

/* bench/tb_top.sv */
// Self-checking bench of the touch ADC sequence controller.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/100ps
`include "tasc_regs.svh"
module tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic touch_i = 1'b0;
  logic acq_inhibit_in_i = 1'b1;
  logic adc_done_i = 1'b0;
  logic [11:0] adc_data_i = 12'h000;
  logic sclk, cs_n, sdi, sdo, ready_n, irq_n, start, sample, adc_pwr, ref_pwr;
  logic [3:0] chan;
  logic [3:0] dly = 4'h0;
  logic [15:0] rd;
  logic [3:0] chans[$];
  int n_conv = 0;
  int miscompares = 0;
  int check_count = 0;

  // ============================================================
  // Clock, design and partners
  always #25 ref_clk_i = ~ref_clk_i;

  tasc_top #(.FCD_LONG_CLKS(40), .TMR_LONG_CLKS(40)) u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .touch_i(touch_i), .acq_inhibit_in_i(acq_inhibit_in_i),
    .adc_done_i(adc_done_i), .adc_data_i(adc_data_i), .sdo_o(sdo), .results_ready_n_o(ready_n),
    .touch_irq_n_o(irq_n), .adc_start_o(start), .adc_chan_o(chan), .sample_o(sample),
    .adc_power_o(adc_pwr), .ref_power_o(ref_pwr));

  tasc_host_model u_host (.ref_clk_i(ref_clk_i), .sdo_i(sdo), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));

  // Converter stand-in; sample data rises by 2 so averages are known
  always @(posedge ref_clk_i) begin
    adc_done_i <= #1 (dly == 4'h1);
    adc_data_i <= #1 {chan, 8'h00} + 12'(2 * (n_conv % 4));
    if (dly == 4'h1) n_conv <= n_conv + 1;
    dly <= start ? 4'h5 : (dly != 4'h0 ? dly - 4'h1 : 4'h0);
    if (start) chans.push_back(chan);
  end

  // ============================================================
  // Helpers
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    u_host.xfer({a, d}, rd);
  endtask

  // Select a register, then read it with a frame to the dead address
  task automatic rdreg(input logic [3:0] a, input logic [11:0] exp, input string what);
    wr(`TASC_ADDR_MODE_CTRL, {8'h00, a});
    u_host.xfer(16'h0000, rd);
    chk(rd[11:0], exp, what);
  endtask

  // ============================================================
  // Scenarios
  task automatic t_regs();
    wr(`TASC_ADDR_TIMING, 12'h90a);
    wr(`TASC_ADDR_SLAVE_MASK, 12'hfff);
    wr(`TASC_ADDR_MASTER_MASK, 12'h001);
    rdreg(`TASC_ADDR_TIMING, 12'h90a, "timing readback");
    rdreg(`TASC_ADDR_SLAVE_MASK, 12'hffe, "slave mask bit 0");
    rdreg(`TASC_ADDR_MASTER_MASK, 12'h000, "master mask bit 0");
  endtask

  // Policy 00 must swallow a start request
  task automatic t_off();
    wr(`TASC_ADDR_TIMING, 12'h000);
    wr(`TASC_ADDR_SLAVE_MASK, 12'h800);
    wr(`TASC_ADDR_MODE_CTRL, 12'h800);
    #15000;
    chk(12'(chans.size()), 12'h000, "converted while powered off");
    chk({11'h0, adc_pwr}, 12'h000, "powered under policy 00");
  endtask

  // Slave run of ch0 and ch3, 4 averages, inhibit held at first
  task automatic t_slave();
    wr(`TASC_ADDR_TIMING, 12'h440);
    wr(`TASC_ADDR_SLAVE_MASK, 12'h900);
    wr(`TASC_ADDR_MASTER_MASK, 12'h400);
    acq_inhibit_in_i = 1'b0;
    wr(`TASC_ADDR_MODE_CTRL, 12'h800);
    #15000;
    chk({11'h0, sample} | 12'(chans.size()), 12'h000, "sampled while inhibited");
    acq_inhibit_in_i = 1'b1;
    for (int i = 0; i < 4000 && ready_n !== 1'b0; i++) #50;
    chk({11'h0, ready_n}, 12'h000, "no results flag");
    chk(12'(chans.size()), 12'h008, "conversion count");
    for (int i = 0; i < 8; i++) chk({8'h00, chans[i]}, i < 4 ? 12'h000 : 12'h003, "channel order");
    #5000;
    chk({10'h0, adc_pwr, ref_pwr}, 12'h000, "power left on when idle");
    rdreg(4'h8, 12'h303, "averaged result");
    chk({11'h0, ready_n}, 12'h001, "flag kept after read");
  endtask

  task automatic t_touch();
    touch_i = 1'b1;
    #500;
    chk({11'h0, irq_n}, 12'h000, "touch not flagged");
    touch_i = 1'b0;
    #500;
    chk({11'h0, irq_n}, 12'h001, "touch flag stuck");
  endtask

  // Master run of ch1 on a touch released while converting
  task automatic t_master();
    wr(`TASC_ADDR_TIMING, 12'h040);
    wr(`TASC_ADDR_MODE_CTRL, 12'hc00);
    touch_i = 1'b1;
    #1000 touch_i = 1'b0;
    #500;
    chk({11'h0, irq_n}, 12'h000, "touch flag dropped while converting");
    for (int i = 0; i < 2000 && ready_n !== 1'b0; i++) #50;
    chk({11'h0, ready_n}, 12'h000, "no master results");
    chk(12'(chans.size()), 12'h009, "master conversion count");
    chk({8'h00, chans[chans.size() - 1]}, 12'h001, "master channel");
    #1000;
    chk({11'h0, irq_n}, 12'h001, "touch flag held after idle");
  endtask

  task automatic conclude();
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    #200;
    chk({7'h0, ready_n, irq_n, adc_pwr, ref_pwr, sdo}, 12'h018, "reset outputs");
    t_regs();
    t_off();
    t_slave();
    t_touch();
    t_master();
    conclude();
  end

  // Run needs about 4200 cycles; give it over nine times that
  initial begin
    #2000000;
    miscompares++;
    conclude();
  end
endmodule // tb_top
